// ==== design/sisl_consts.svh ====
`ifndef SISL_CONSTS_SVH
`define SISL_CONSTS_SVH

// register offsets in the 15-bit space
`define SISL_ADDR_FAMILY     15'h0003
`define SISL_ADDR_PART_LO    15'h0004
`define SISL_ADDR_PART_HI    15'h0005
`define SISL_ADDR_GRADE      15'h0006
`define SISL_ADDR_SCRATCH    15'h000a
`define SISL_ADDR_IF_REV     15'h000b
`define SISL_ADDR_MAKER_LO   15'h000c
`define SISL_ADDR_MAKER_HI   15'h000d
`define SISL_ADDR_WRAP_CNT   15'h000e
`define SISL_ADDR_XFER_CTRL  15'h000f

// reset values
`define SISL_RST_SCRATCH     8'h00
`define SISL_RST_WRAP_CNT    8'h00
`define SISL_RST_RETAIN      1'b0

// field positions
`define SISL_RETAIN_BIT      2
`define SISL_INSTR_RD_BIT    15

// framing counts
`define SISL_INSTR_LAST      4'hf
`define SISL_BYTE_LAST       4'h7
`define SISL_ADDR_STEP       15'h0001
`define SISL_COUNT_STEP      8'h01

`endif

// ==== design/sisl_pkg.sv ====
package sisl_pkg;

  // serial frame phases, one-hot
  typedef enum logic [3:0] {
    SISL_IDLE  = 4'b0001,
    SISL_INSTR = 4'b0010,
    SISL_DATA  = 4'b0100,
    SISL_DONE  = 4'b1000
  } sisl_state_t;

endpackage

// ==== design/sisl_regs.sv ====
`timescale 1ns/1ps
`include "sisl_consts.svh"

// Summary of operation
// RQ1: The family register shows a fixed 4-bit family code in bits 3 to 0 and reads zero in bits 7 to 4.
// RQ2: The 16-bit part code reads low byte at the lower address and high byte at the next one.
// RQ3: The grade register shows the performance grade in its upper nibble.
// RQ4: The grade register shows the hardware revision in its lower nibble.
// RQ5: The scratch byte stores whatever is written and returns it, affecting nothing else.
// RQ6: The interface revision reads a 2-bit type in bits 7 to 6 and a 6-bit version in bits 5 to 0.
// RQ7: The 16-bit maker code reads low byte at the lower address and high byte at the next one.
// RQ8: A nonzero wrap count sends the streaming address back to the start address after that many bytes.
// RQ9: A zero wrap count disables loop-back and the address wraps at the ends of the address space.
// RQ10: A written wrap count serves only the next instruction and clears itself when that instruction ends.
// RQ11: With the retain bit set the wrap count is not cleared on the chip-select rising edge.
// RQ12: The controller is expected to leave the wrap count at zero and not depend on loop-back.
// RQ13: The controller writes zeros to the reserved bits of the transfer control register.
// RQ14: Streaming steps the address by one per byte, up when walk direction is 1 and down when 0.
// RQ15: One-shot instruction mode allows only one data byte per instruction, otherwise streaming.
// RQ16: Writes to the identification and revision registers change nothing.
module sisl_regs #(
  parameter logic [3:0]  FAMILY_CODE  = 4'h9,     // arbitrary value
  parameter logic [15:0] PART_CODE    = 16'h5a3c, // arbitrary value
  parameter logic [3:0]  GRADE        = 4'h5,     // arbitrary value
  parameter logic [3:0]  HW_REVISION  = 4'h6,     // arbitrary value
  parameter logic [1:0]  IF_TYPE      = 2'h1,     // arbitrary value
  parameter logic [5:0]  IF_VERSION   = 6'h2a,    // arbitrary value
  parameter logic [15:0] MAKER_CODE   = 16'hbe71  // arbitrary value
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic walk_direction,
  input  wire logic one_shot_instruction,
  output logic      sdo,
  output logic      sdo_oe_n
);
  import sisl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  sisl_state_t state,        next_state;
  logic        sclk_q,       next_sclk_q;
  logic        cs_q,         next_cs_q;
  logic [3:0]  bit_cnt,      next_bit_cnt;
  logic [15:0] rx_sr,        next_rx_sr;
  logic        is_read,      next_is_read;
  logic [14:0] cur_addr,     next_cur_addr;
  logic [14:0] start_addr,   next_start_addr;
  logic [7:0]  byte_cnt,     next_byte_cnt;
  logic [7:0]  loop_len,     next_loop_len;
  logic [7:0]  scratch,      next_scratch;
  logic [7:0]  wrap_count,   next_wrap_count;
  logic        retain,       next_retain;
  logic        wrap_written, next_wrap_written;
  logic        load_pending, next_load_pending;
  logic [7:0]  tx_sr,        next_tx_sr;
  logic        next_sdo;
  logic        next_sdo_oe_n;

  // edge strobes from the sampled pins
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic [15:0] instr_word;
  logic [7:0]  data_byte;
  logic [7:0]  rd_byte;
  logic [14:0] stepped_addr;
  logic        wr_byte;

  // register images, one byte per mapped location
  logic [7:0]  family_byte;
  logic [7:0]  part_lo_byte;
  logic [7:0]  part_hi_byte;
  logic [7:0]  grade_byte;
  logic [7:0]  if_rev_byte;
  logic [7:0]  maker_lo_byte;
  logic [7:0]  maker_hi_byte;
  logic [7:0]  xfer_byte;

  //////////////////////////////////////////////////////////////////////////////
  // pin edges; pins are synchronous so one history flop is enough
  // serial edges count only inside a frame, so clocks on a shared bus while
  // select is high never disturb the engine
  assign sclk_rise  = sclk & ~sclk_q & ~cs_n;
  assign sclk_fall  = ~sclk & sclk_q & ~cs_n;
  assign cs_rise    = cs_n & ~cs_q;
  assign cs_fall    = ~cs_n & cs_q;
  assign instr_word = {rx_sr[14:0], sdi};
  assign data_byte  = {rx_sr[6:0], sdi};

  // next address in the walk, wraps at both ends of the space
  // the 15-bit adder wraps on its own, so no limit compare is needed
  assign stepped_addr = walk_direction ? (cur_addr + `SISL_ADDR_STEP) : (cur_addr - `SISL_ADDR_STEP); // RQ14 RQ9

  // a completed write byte; select edges win over serial edges in the engine
  // reads never write, so a streamed read cannot disturb the scratch byte
  assign wr_byte = (state == SISL_DATA) && sclk_rise && (bit_cnt == `SISL_BYTE_LAST) && !is_read && !cs_fall;

  //////////////////////////////////////////////////////////////////////////////
  // fixed identity images; tied to parameters so no write path can reach them
  // images are plain wires; they cost no flip-flops
  assign family_byte   = {4'h0, FAMILY_CODE};     // RQ1
  assign part_lo_byte  = PART_CODE[7:0];          // RQ2
  assign part_hi_byte  = PART_CODE[15:8];         // RQ2
  assign grade_byte    = {GRADE, HW_REVISION};    // RQ3 RQ4
  assign if_rev_byte   = {IF_TYPE, IF_VERSION};   // RQ6
  assign maker_lo_byte = MAKER_CODE[7:0];         // RQ7
  assign maker_hi_byte = MAKER_CODE[15:8];        // RQ7
  // reserved bits of the transfer control read back zero whatever was written
  assign xfer_byte     = {5'h00, retain, 2'h0};

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  // the mux follows the live address, so a streamed read picks up each byte as
  // the walk reaches it; nothing is prefetched ahead of the fall that loads it
  always_comb begin
    case (cur_addr)
      `SISL_ADDR_FAMILY:    rd_byte = family_byte;   // RQ1
      `SISL_ADDR_PART_LO:   rd_byte = part_lo_byte;  // RQ2
      `SISL_ADDR_PART_HI:   rd_byte = part_hi_byte;  // RQ2
      `SISL_ADDR_GRADE:     rd_byte = grade_byte;    // RQ3 RQ4
      `SISL_ADDR_SCRATCH:   rd_byte = scratch;       // RQ5
      `SISL_ADDR_IF_REV:    rd_byte = if_rev_byte;   // RQ6
      `SISL_ADDR_MAKER_LO:  rd_byte = maker_lo_byte; // RQ7
      `SISL_ADDR_MAKER_HI:  rd_byte = maker_hi_byte; // RQ7
      `SISL_ADDR_WRAP_CNT:  rd_byte = wrap_count;
      `SISL_ADDR_XFER_CTRL: rd_byte = xfer_byte;
      default:              rd_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next values for the frame engine
  // frame layout: select falls, sixteen instruction bits (read flag, then a
  // 15-bit address, msb first), then data bytes msb first until select rises.
  // a partial byte at the select rise is dropped without touching any register.
  // one-shot mode parks the engine in its done state; extra clocks only shift
  // zeros out, so a controller that over-clocks reads back zero bytes.
  // serial edges are seen one system clock late, so each serial level must last
  // at least one system clock; faster serial clocks lose bits without warning.
  always_comb begin
    next_state        = state;
    next_bit_cnt      = bit_cnt;
    next_rx_sr        = rx_sr;
    next_is_read      = is_read;
    next_cur_addr     = cur_addr;
    next_start_addr   = start_addr;
    next_byte_cnt     = byte_cnt;
    next_loop_len     = loop_len;
    next_load_pending = load_pending;
    next_tx_sr        = tx_sr;
    next_sdo          = sdo;
    next_sdo_oe_n     = sdo_oe_n;

    if (cs_rise) begin
      // end of instruction; the data line is let go at once
      next_state        = SISL_IDLE;
      next_sdo_oe_n     = 1'b1;
      next_sdo          = 1'b0;
      next_load_pending = 1'b0;
    end else if (cs_fall) begin
      next_state        = SISL_INSTR;
      next_bit_cnt      = 4'h0;
      next_load_pending = 1'b0;
    end else begin
      case (state)
        SISL_INSTR: begin
          // the instruction word is complete on its sixteenth rise
          if (sclk_rise) begin
            next_rx_sr   = instr_word;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `SISL_INSTR_LAST) begin
              next_state        = SISL_DATA;
              next_bit_cnt      = 4'h0;
              next_is_read      = instr_word[`SISL_INSTR_RD_BIT];
              next_cur_addr     = instr_word[14:0];
              next_start_addr   = instr_word[14:0];
              next_byte_cnt     = 8'h00;
              next_loop_len     = wrap_count; // RQ10
              next_load_pending = instr_word[`SISL_INSTR_RD_BIT];
            end
          end
        end
        SISL_DATA: begin
          if (sclk_rise) begin
            next_rx_sr   = {8'h00, data_byte};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `SISL_BYTE_LAST) begin
              next_bit_cnt = 4'h0;
              // the write itself lands in the configuration group through wr_byte
              if (one_shot_instruction) begin
                next_state = SISL_DONE; // RQ15
              end else begin
                next_load_pending = is_read;
                next_byte_cnt     = byte_cnt + `SISL_COUNT_STEP;
                next_cur_addr     = stepped_addr; // RQ14
                if ((loop_len != 8'h00) && (next_byte_cnt == loop_len)) begin
                  next_cur_addr = start_addr; // RQ8
                  next_byte_cnt = 8'h00;
                end
              end
            end
          end
          if (sclk_fall) begin
            // shift on the falling edge so the controller samples on the rising one
            // the first fall after the instruction loads the addressed byte
            if (load_pending) begin
              next_sdo          = rd_byte[7];
              next_tx_sr        = {rd_byte[6:0], 1'b0};
              next_sdo_oe_n     = 1'b0;
              next_load_pending = 1'b0;
            end else begin
              next_sdo   = tx_sr[7];
              next_tx_sr = {tx_sr[6:0], 1'b0};
            end
          end
        end
        SISL_DONE: begin
          // further rises in a one-shot frame are ignored; falls only shift zeros out
          if (sclk_fall) begin
            next_sdo   = tx_sr[7];
            next_tx_sr = {tx_sr[6:0], 1'b0};
          end
        end
        SISL_IDLE: begin
          // output stays released between frames; the data line may be shared
          next_sdo_oe_n = 1'b1;
        end
        default: begin
          next_state = SISL_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame engine registers, frozen while ce is low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state        <= SISL_IDLE;
      bit_cnt      <= 4'h0;
      rx_sr        <= 16'h0000;
      is_read      <= 1'b0;
      cur_addr     <= 15'h0000;
      start_addr   <= 15'h0000;
      byte_cnt     <= 8'h00;
      loop_len     <= 8'h00;
      load_pending <= 1'b0;
      tx_sr        <= 8'h00;
      sdo          <= 1'b0;
      sdo_oe_n     <= 1'b1;
    end else if (ce) begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      rx_sr        <= next_rx_sr;
      is_read      <= next_is_read;
      cur_addr     <= next_cur_addr;
      start_addr   <= next_start_addr;
      byte_cnt     <= next_byte_cnt;
      loop_len     <= next_loop_len;
      load_pending <= next_load_pending;
      tx_sr        <= next_tx_sr;
      sdo          <= next_sdo;
      sdo_oe_n     <= next_sdo_oe_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin history; frozen with ce too, so a stalled engine never fakes an edge
  always_comb begin
    next_sclk_q = sclk;
    next_cs_q   = cs_n;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      // deasserted history, so a select already low at release starts a frame
      cs_q   <= 1'b1;
    end else if (ce) begin
      sclk_q <= next_sclk_q;
      cs_q   <= next_cs_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers; a count written inside a frame survives its end
  // the write decode lives here so the frame engine only walks addresses;
  // a write lands one system clock after the eighth serial rise of its byte
  always_comb begin
    next_scratch      = scratch;
    next_wrap_count   = wrap_count;
    next_retain       = retain;
    next_wrap_written = wrap_written;
    if (cs_rise) begin
      // the retain bit trades the automatic clear for a count kept across frames
      if (!retain && !wrap_written) begin // RQ11
        next_wrap_count = `SISL_RST_WRAP_CNT; // RQ10
      end
    end else if (cs_fall) begin
      next_wrap_written = 1'b0;
    end else if (wr_byte) begin
      // only the writable locations are decoded; identity bytes ignore writes
      case (cur_addr)
        `SISL_ADDR_SCRATCH: begin
          next_scratch = data_byte; // RQ5
        end
        `SISL_ADDR_WRAP_CNT: begin
          next_wrap_count   = data_byte;
          next_wrap_written = 1'b1;
        end
        `SISL_ADDR_XFER_CTRL: begin
          next_retain = data_byte[`SISL_RETAIN_BIT];
        end
        default: begin
          next_scratch = scratch; // RQ16
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scratch      <= `SISL_RST_SCRATCH;
      wrap_count   <= `SISL_RST_WRAP_CNT;
      retain       <= `SISL_RST_RETAIN;
      wrap_written <= 1'b0;
    end else if (ce) begin
      scratch      <= next_scratch;
      wrap_count   <= next_wrap_count;
      retain       <= next_retain;
      wrap_written <= next_wrap_written;
    end
  end

endmodule

// ==== verif/sisl_regs_sva.sv ====
`timescale 1ns/1ps
module sisl_regs_sva (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic       sclk_q;
  logic [4:0] rises;
  logic [4:0] next_rises;
  // serial rises in a frame; saturates so long streams never alias to 16
  always_comb begin
    next_rises = cs_n ? 5'h00 : rises;
    if (!cs_n && sclk && !sclk_q && rises != 5'h1f) next_rises = rises + 5'h01;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      rises  <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rises  <= next_rises;
    end
  end
  a_oe_idle_off: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> sdo_oe_n)
    else $error("sdo enabled outside a frame");
  a_sdo_idle_low: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !sdo)
    else $error("sdo not low while idle");
  a_oe_after_instr: assert property ($fell(sdo_oe_n) |-> rises == 5'h10)
    else $error("sdo enabled before instruction end");
  a_oe_on_fall: assert property ($fell(sdo_oe_n) |-> !cs_n && !$past(sclk))
    else $error("sdo enabled off a serial fall");
  a_sdo_on_fall: assert property ($changed(sdo) && !sdo_oe_n && !cs_n |-> !$past(sclk))
    else $error("sdo moved while serial clock high");
  a_sdo_hold_high: assert property (!sdo_oe_n && sclk && $past(sclk) |-> $stable(sdo))
    else $error("sdo unstable in high phase");
  a_oe_holds_frame: assert property (!sdo_oe_n && !cs_n |=> !sdo_oe_n)
    else $error("sdo released inside frame");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:3] sdo_oe_n)
    else $error("sdo not released after frame");
  c_read: cover property ($fell(sdo_oe_n));
  c_end: cover property ($rose(cs_n));
  c_long: cover property (rises == 5'h1f);
endmodule
//////////////////////////////////////////////////////////////////////
bind sisl_regs sisl_regs_sva i_sva (
  .clk_sys  (clk_sys),
  .rstn     (rstn),
  .cs_n     (cs_n),
  .sclk     (sclk),
  .sdo      (sdo),
  .sdo_oe_n (sdo_oe_n)
);

// ==== verif/sisl_spi_host.sv ====
`timescale 1ns/1ps
module sisl_spi_host #(parameter int HALF = 3) (
  input  wire logic clk_sys,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  // bytes to send or bytes received; never programs a loop count itself
  logic [7:0] data_q[$];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // inputs move 1 ns after an edge so no race with the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // mode 0 byte, msb first: set sdi low phase, read sdo just before the rise
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      tick(HALF);
      rx[i] = sdo;
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic rd, input logic [14:0] addr, input int n);
    logic [7:0] rx;
    tick(1);
    cs_n = 1'b0;
    shift8({rd, addr[14:8]}, rx);
    shift8(addr[7:0], rx);
    for (int k = 0; k < n; k++) begin
      shift8(rd ? 8'h00 : data_q.pop_front(), rx);
      if (rd) data_q.push_back(rx);
    end
    tick(HALF);
    cs_n = 1'b1;
    sdi  = ~sdi; // released line must not keep its last value
    tick(HALF);
  endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0]  FAM = 4'hb, GRD = 4'h9, REV = 4'hd; // arbitrary values
  localparam logic [15:0] PART = 16'hc4e1, MAK = 16'h7a9e;     // arbitrary values
  localparam logic [1:0]  IFT = 2'h3;                          // arbitrary value
  localparam logic [5:0]  IFV = 6'h15;                         // arbitrary value
  logic       clk_sys, rstn, ce, walk_direction, one_shot_instruction, cs_n, sclk, sdi, sdo, sdo_oe_n;
  logic [7:0] m_scr, m_cnt, wq[$];
  logic       m_keep;
  int         n_errors = 0;
  int         n_tests = 0;
  sisl_regs #(.FAMILY_CODE(FAM), .PART_CODE(PART), .GRADE(GRD), .HW_REVISION(REV), .IF_TYPE(IFT),
    .IF_VERSION(IFV), .MAKER_CODE(MAK)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .walk_direction(walk_direction), .one_shot_instruction(one_shot_instruction),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  sisl_spi_host i_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////
  // reference register map
  function automatic logic [7:0] m_read(input logic [14:0] a);
    case (a)
      15'h0003: return {4'h0, FAM};
      15'h0004: return PART[7:0];
      15'h0005: return PART[15:8];
      15'h0006: return {GRD, REV};
      15'h000a: return m_scr;
      15'h000b: return {IFT, IFV};
      15'h000c: return MAK[7:0];
      15'h000d: return MAK[15:8];
      15'h000e: return m_cnt;
      15'h000f: return {5'h00, m_keep, 2'h0};
      default:  return 8'h00;
    endcase
  endfunction
  task automatic rnd(input int n);
    repeat (n) wq.push_back(8'($urandom));
  endtask
  // one frame on the pins, then replay it on the model and compare reads
  task automatic run(input logic rd, input logic [14:0] a0, input int n);
    logic [14:0] a;
    logic [7:0]  e, w;
    int          lim, cnt;
    bit          wrote, skip;
    a = a0;
    lim = m_cnt;
    cnt = 0;
    wrote = 0;
    foreach (wq[k]) i_host.data_q.push_back(wq[k]);
    i_host.frame(rd, a0, n);
    for (int k = 0; k < n; k++) begin
      skip = one_shot_instruction && k > 0;
      w = rd ? i_host.data_q.pop_front() : wq.pop_front();
      e = skip ? 8'h00 : m_read(a);
      if (rd) n_tests++;
      if (rd && w !== e) begin
        n_errors++;
        $display("[ERR] reg 0x%0h exp 0x%h got 0x%h", a, e, w);
      end
      if (!rd && !skip && a == 15'h000a) m_scr = w;
      if (!rd && !skip && a == 15'h000e) {m_cnt, wrote} = {w, 1'b1};
      if (!rd && !skip && a == 15'h000f) m_keep = w[2];
      a = walk_direction ? a + 15'h0001 : a - 15'h0001;
      cnt++;
      if (lim != 0 && cnt == lim) {a, cnt} = {a0, 32'd0};
    end
    if (!m_keep && !wrote) m_cnt = 8'h00;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
  initial begin
    {rstn, walk_direction, one_shot_instruction, m_scr, m_cnt, m_keep} = {3'b010, 17'h0};
    ce = 1'b1;
    void'($urandom(78));
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    run(1'b1, 15'h0003, 13);
    repeat (4) begin
      rnd(1);
      run(1'b0, 15'h000a, 1);
      run(1'b1, 15'h000a, 1);
    end
    // a frozen engine must ignore a whole frame and keep its scratch byte
    ce = 1'b0;
    i_host.data_q.push_back(~m_scr);
    i_host.frame(1'b0, 15'h000a, 1);
    ce = 1'b1;
    run(1'b1, 15'h000a, 1);
    walk_direction = 1'b0;
    rnd(4);
    run(1'b0, 15'h0006, 4);
    walk_direction = 1'b1;
    run(1'b1, 15'h0003, 4);
    rnd(15);
    run(1'b0, 15'h7fff, 15);
    run(1'b1, 15'h0003, 11);
    one_shot_instruction = 1'b1;
    rnd(2);
    run(1'b0, 15'h0009, 2);
    run(1'b1, 15'h000a, 2);
    one_shot_instruction = 1'b0;
    wq.push_back(8'h02);
    run(1'b0, 15'h000e, 1);
    rnd(3);
    run(1'b0, 15'h000a, 3);
    run(1'b1, 15'h000a, 5);
    wq.push_back(8'h04);
    run(1'b0, 15'h000f, 1);
    wq.push_back(8'h02);
    run(1'b0, 15'h000e, 1);
    repeat (2) begin
      rnd(3);
      run(1'b0, 15'h000a, 3);
      run(1'b1, 15'h000a, 1);
    end
    run(1'b1, 15'h000e, 3);
    wrap_up();
  end
endmodule
